// [logic/sbl_boot_loader.sv]
// Serial boot loader: mode latch, bit rate measurement, handshake, download, branch
`timescale 1ns/1ps
`include "sbl_defines.svh"
module sbl_boot_loader #(
  parameter int LOAD_BYTES = `SBL_WIN_BYTES,
  parameter int DIV_W = 16
) (
  // Clock and resets
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic WDT_RST_I,
  // Mode pins
  input wire logic FLASH_SUPPLY_HV_I,
  input wire logic MODE_SEL_HV_I,
  output logic BOOT_MODE_O,
  // Serial line
  input wire logic RXD_I,
  output logic TXD_O,
  output logic TXD_OE_O,
  // Flash erase
  input wire logic FLASH_BLANK_I,
  input wire logic FLASH_ERASE_DONE_I,
  output logic FLASH_ERASE_O,
  output logic INT_BLOCK_O,
  // RAM write and reserved area
  output sbl_pkg::sbl_ram_wr_t RAM_WR_O,
  output logic RES_RAM_BUSY_O,
  // CPU branch
  output logic CPU_BRANCH_O,
  output logic [15:0] CPU_PC_O,
  // Register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  output logic [15:0] REG_RDATA_O
);
  import sbl_pkg::*;
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (LOAD_BYTES < 1 || LOAD_BYTES > `SBL_WIN_BYTES) begin : g_chk_len
    $error("LOAD_BYTES must lie within the program window");
  end
  if (DIV_W < 8 || DIV_W > 16) begin : g_chk_div
    $error("DIV_W must lie between 8 and 16");
  end
  localparam logic [15:0] LAST_IDX = 16'(LOAD_BYTES - 1);
  localparam logic [15:0] READY_CYC = 16'(`SBL_READY_CYC);
  localparam logic [3:0] MEAS_LAST = 4'(`SBL_MEAS_BITS - 1);
  localparam logic [DIV_W-1:0] DIV_MAX = '1;
  localparam logic [1:0] CTRL_RST = `SBL_CTRL_RST;
  // ****************************************
  // Declarations
  // ****************************************
  sbl_state_t state_q;
  logic rst_q;
  logic boot_q;
  logic loader_rst;
  logic [15:0] cnt_q;
  logic [3:0] pre_q;
  logic [DIV_W-1:0] div_q;
  logic rx_on_q;
  logic tx_on_q;
  logic ack_sent_q;
  logic erase_q;
  logic branch_q;
  logic [15:0] pc_q;
  sbl_ram_wr_t ram_q;
  logic [15:0] rdata_q;
  logic tx_start;
  logic tx_busy;
  logic txd_line;
  logic rx_valid;
  logic [7:0] rx_data;
  logic sw_ctrl_we;
  logic sw_baud_we;
  assign loader_rst = RST_I | WDT_RST_I;
  assign sw_ctrl_we = REG_WE_I && (REG_ADDR_I == `SBL_REG_CTRL);
  assign sw_baud_we = REG_WE_I && (REG_ADDR_I == `SBL_REG_BAUD);
  // ****************************************
  // Boot mode latch
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    rst_q <= RST_I;
  end
  // Watchdog reset leaves the latch alone
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      boot_q <= 1'b0;
    end else if (rst_q) begin
      boot_q <= FLASH_SUPPLY_HV_I & MODE_SEL_HV_I;
    end else if (!MODE_SEL_HV_I) begin
      boot_q <= 1'b0;
    end
  end
  // ****************************************
  // Loader sequence
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst) begin
      state_q <= SBL_IDLE;
    end else if (!boot_q) begin
      state_q <= SBL_IDLE;
    end else begin
      case (state_q)
        SBL_IDLE: begin
          state_q <= SBL_READY;
        end
        SBL_READY: begin
          if (cnt_q == READY_CYC - 16'h0001) begin
            state_q <= SBL_LOWW;
          end
        end
        SBL_LOWW: begin
          if (!RXD_I) begin
            state_q <= SBL_LOWM;
          end
        end
        SBL_LOWM: begin
          if (RXD_I) begin
            state_q <= (div_q == '0) ? SBL_LOWW : SBL_ACK;
          end
        end
        SBL_ACK: begin
          if (ack_sent_q && !tx_busy) begin
            state_q <= SBL_SYNC;
          end
        end
        SBL_SYNC: begin
          if (rx_valid && rx_data == `SBL_SYNC_BYTE) begin
            state_q <= SBL_ERASE;
          end
        end
        SBL_ERASE: begin
          if (FLASH_BLANK_I || FLASH_ERASE_DONE_I) begin
            state_q <= SBL_LOAD;
          end
        end
        SBL_LOAD: begin
          if (rx_valid && cnt_q == LAST_IDX) begin
            state_q <= SBL_BRANCH;
          end
        end
        SBL_BRANCH: begin
          if (!tx_busy) begin
            state_q <= SBL_DONE;
          end
        end
        SBL_DONE: begin
          state_q <= SBL_DONE;
        end
        default: begin
          state_q <= SBL_IDLE;
        end
      endcase
    end
  end
  // ****************************************
  // Ready delay and load index
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst) begin
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        SBL_READY: begin
          cnt_q <= cnt_q + 16'h0001;
        end
        SBL_LOAD: begin
          if (rx_valid) begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          cnt_q <= 16'h0000;
        end
      endcase
    end
  end
  // ****************************************
  // Low period measurement
  // ****************************************
  // One divisor step per nine low clocks gives clocks per bit
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst) begin
      pre_q <= 4'h0;
    end else if (state_q == SBL_LOWM && !RXD_I) begin
      pre_q <= (pre_q == MEAS_LAST) ? 4'h0 : pre_q + 4'h1;
    end else begin
      pre_q <= 4'h0;
    end
  end
  // Hardware update wins over a software write
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      div_q <= DIV_W'(`SBL_BAUD_RST);
    end else if (state_q == SBL_LOWW && !RXD_I && boot_q && !WDT_RST_I) begin
      div_q <= '0;
    end else if (state_q == SBL_LOWM && !RXD_I && pre_q == MEAS_LAST && div_q != DIV_MAX) begin
      div_q <= div_q + 1'b1;
    end else if (sw_baud_we) begin
      div_q <= REG_WDATA_I[DIV_W-1:0];
    end
  end
  // ****************************************
  // Serial control bits
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rx_on_q <= CTRL_RST[`SBL_RX_ON_POS];
      tx_on_q <= CTRL_RST[`SBL_TX_ON_POS];
    end else if (state_q == SBL_LOWM && RXD_I && div_q != '0) begin
      rx_on_q <= 1'b1;
      tx_on_q <= 1'b1;
    end else if (state_q == SBL_BRANCH) begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
    end else if (sw_ctrl_we) begin
      rx_on_q <= REG_WDATA_I[`SBL_RX_ON_POS];
      tx_on_q <= REG_WDATA_I[`SBL_TX_ON_POS];
    end
  end

  // ****************************************
  // Acknowledge byte
  // ****************************************
  assign tx_start = (state_q == SBL_ACK) && tx_on_q && !ack_sent_q && !tx_busy;
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst || state_q != SBL_ACK) begin
      ack_sent_q <= 1'b0;
    end else if (tx_start) begin
      ack_sent_q <= 1'b1;
    end
  end
  sbl_uart_tx #(
    .DIV_W(DIV_W)
  ) u_tx (
    .clk_i(CORE_CLK_I),
    .rst_i(loader_rst),
    .div_i(div_q),
    .start_i(tx_start),
    .data_i(`SBL_ACK_BYTE),
    .busy_o(tx_busy),
    .txd_o(txd_line)
  );
  sbl_uart_rx #(
    .DIV_W(DIV_W)
  ) u_rx (
    .clk_i(CORE_CLK_I),
    .rst_i(loader_rst),
    .en_i(rx_on_q),
    .div_i(div_q),
    .rxd_i(RXD_I),
    .valid_o(rx_valid),
    .data_o(rx_data)
  );
  // ****************************************
  // Flash erase and interrupt block
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst) begin
      erase_q <= 1'b0;
    end else begin
      erase_q <= boot_q && state_q == SBL_ERASE && !FLASH_BLANK_I && !FLASH_ERASE_DONE_I;
    end
  end
  // ****************************************
  // Program download
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst) begin
      ram_q <= '0;
    end else begin
      ram_q.we <= boot_q && state_q == SBL_LOAD && rx_valid;
      if (state_q == SBL_LOAD && rx_valid) begin
        ram_q.addr <= `SBL_WIN_BASE + cnt_q;
        ram_q.data <= rx_data;
      end
    end
  end
  // ****************************************
  // Branch to the program
  // ****************************************
  // Only the program counter is loaded; the serial enables clear in SBL_BRANCH in the control bits block above
  always_ff @(posedge CORE_CLK_I) begin
    if (loader_rst) begin
      branch_q <= 1'b0;
      pc_q <= 16'h0000;
    end else begin
      branch_q <= boot_q && state_q == SBL_BRANCH && !tx_busy;
      if (state_q == SBL_BRANCH && !tx_busy) begin
        pc_q <= `SBL_WIN_BASE;
      end
    end
  end
  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rdata_q <= 16'h0000;
    end else if (REG_RE_I) begin
      case (REG_ADDR_I)
        `SBL_REG_CTRL: begin
          rdata_q <= {14'h0000, tx_on_q, rx_on_q};
        end
        `SBL_REG_BAUD: begin
          rdata_q <= 16'(div_q);
        end
        `SBL_REG_STAT: begin
          rdata_q <= {3'h0, erase_q, 1'b0, boot_q, state_q};
        end
        `SBL_REG_COUNT: begin
          rdata_q <= cnt_q;
        end
        default: begin
          rdata_q <= 16'h0000;
        end
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign BOOT_MODE_O = boot_q;
  // Idle high line in boot mode; a high output once the program runs
  assign TXD_O = (state_q == SBL_DONE) ? 1'b1 : txd_line;
  assign TXD_OE_O = boot_q;
  assign FLASH_ERASE_O = erase_q;
  assign INT_BLOCK_O = erase_q;
  assign RAM_WR_O = ram_q;
  assign RES_RAM_BUSY_O = boot_q && state_q != SBL_DONE && state_q != SBL_IDLE;
  assign CPU_BRANCH_O = branch_q;
  assign CPU_PC_O = pc_q;
  assign REG_RDATA_O = rdata_q;
endmodule : sbl_boot_loader

// [logic/sbl_defines.svh]
// Constants of the serial boot loader: offsets, fields, reset values, timing
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define SBL_CLK_HZ 40000000
`define SBL_READY_STATES 100
`define SBL_READY_CYC (`SBL_READY_STATES * (`SBL_CLK_HZ / `SBL_CLK_HZ))
`define SBL_MEAS_BITS 9

// ****************************************
// Handshake bytes and flash
// ****************************************
`define SBL_ACK_BYTE 8'h00
`define SBL_SYNC_BYTE 8'h55
`define SBL_ERASED_BYTE 8'hFF

// ****************************************
// RAM map
// ****************************************
`define SBL_RES_LO_BASE 16'hFB80
`define SBL_RES_LO_END 16'hFBDF
`define SBL_INT_KEEP_END 16'hFB8F
`define SBL_RES_HI_BASE 16'hFF6E
`define SBL_RES_HI_END 16'hFF7F
`define SBL_WIN_BASE 16'hFBE0
`define SBL_WIN_END 16'hFF6D
`define SBL_WIN_BYTES 910

// ****************************************
// Register port
// ****************************************
`define SBL_REG_CTRL 4'h0
`define SBL_REG_BAUD 4'h1
`define SBL_REG_STAT 4'h2
`define SBL_REG_COUNT 4'h3
`define SBL_RX_ON_POS 0
`define SBL_TX_ON_POS 1
`define SBL_CTRL_RST 2'h0
`define SBL_BAUD_RST 16'h0000

`endif

// [logic/sbl_pkg.sv]
// Types shared by the serial boot loader modules
package sbl_pkg;

  // ****************************************
  // Loader states, one-hot
  // ****************************************
  typedef enum logic [9:0] {
    SBL_IDLE   = 10'h001,
    SBL_READY  = 10'h002,
    SBL_LOWW   = 10'h004,
    SBL_LOWM   = 10'h008,
    SBL_ACK    = 10'h010,
    SBL_SYNC   = 10'h020,
    SBL_ERASE  = 10'h040,
    SBL_LOAD   = 10'h080,
    SBL_BRANCH = 10'h100,
    SBL_DONE   = 10'h200
  } sbl_state_t;

  // ****************************************
  // RAM write port
  // ****************************************
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } sbl_ram_wr_t;

endpackage : sbl_pkg

// [logic/sbl_uart_rx.sv]
// Asynchronous serial receiver, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
module sbl_uart_rx #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Enable and bit period in clocks
  input wire logic en_i,
  input wire logic [DIV_W-1:0] div_i,
  // Line
  input wire logic rxd_i,
  // Received byte
  output logic valid_o,
  output logic [7:0] data_o
);
  logic rxd_q;
  logic busy_q;
  logic [3:0] bit_q;
  logic [DIV_W-1:0] tmr_q;
  logic [7:0] sh_q;
  logic valid_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_q <= 1'b1;
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      tmr_q <= '0;
      sh_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      rxd_q <= rxd_i;
      valid_q <= 1'b0;
      if (!busy_q) begin
        // Start edge, first sample at mid bit
        if (en_i && rxd_q && !rxd_i) begin
          busy_q <= 1'b1;
          bit_q <= 4'h0;
          tmr_q <= {1'b0, div_i[DIV_W-1:1]};
        end
      end else if (tmr_q > 1) begin
        tmr_q <= tmr_q - 1'b1;
      end else begin
        tmr_q <= div_i;
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'h0 && rxd_i) begin
          busy_q <= 1'b0;
        end else if (bit_q == 4'h9) begin
          busy_q <= 1'b0;
          valid_q <= rxd_i;
        end else if (bit_q != 4'h0) begin
          sh_q <= {rxd_i, sh_q[7:1]};
        end
      end
    end
  end

  assign valid_o = valid_q;
  assign data_o = sh_q;
endmodule : sbl_uart_rx

// [logic/sbl_uart_tx.sv]
// Asynchronous serial transmitter, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
module sbl_uart_tx #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bit period in clocks
  input wire logic [DIV_W-1:0] div_i,
  // Byte request
  input wire logic start_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  // Line
  output logic txd_o
);
  logic [9:0] sh_q;
  logic [3:0] bit_q;
  logic [DIV_W-1:0] tmr_q;
  logic busy_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q <= 10'h3FF;
      bit_q <= 4'h0;
      tmr_q <= '0;
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      if (start_i) begin
        sh_q <= {1'b1, data_i, 1'b0};
        bit_q <= 4'h0;
        tmr_q <= div_i;
        busy_q <= 1'b1;
      end
    end else if (tmr_q > 1) begin
      tmr_q <= tmr_q - 1'b1;
    end else begin
      tmr_q <= div_i;
      sh_q <= {1'b1, sh_q[9:1]};
      bit_q <= bit_q + 4'h1;
      if (bit_q == 4'h9) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign busy_o = busy_q;
  assign txd_o = busy_q ? sh_q[0] : 1'b1;
endmodule : sbl_uart_tx

// [tb/sbl_boot_loader_checker.sv]
// Port assertions for the serial boot loader
`timescale 1ns/1ps
module sbl_boot_loader_checker
  import sbl_pkg::*;
#(
  parameter int LOAD_BYTES = 4
) (
  // Clock and resets
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic WDT_RST_I,
  // Mode pins and serial line
  input wire logic FLASH_SUPPLY_HV_I,
  input wire logic MODE_SEL_HV_I,
  input wire logic BOOT_MODE_O,
  input wire logic TXD_O,
  input wire logic TXD_OE_O,
  // Flash and RAM
  input wire logic FLASH_BLANK_I,
  input wire logic FLASH_ERASE_DONE_I,
  input wire logic FLASH_ERASE_O,
  input wire logic INT_BLOCK_O,
  input wire sbl_pkg::sbl_ram_wr_t RAM_WR_O,
  input wire logic RES_RAM_BUSY_O,
  // Branch
  input wire logic CPU_BRANCH_O,
  input wire logic [15:0] CPU_PC_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  // ****************************************
  // Download address tracking
  // ****************************************
  logic wr_seen_q;
  logic [15:0] last_addr_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || WDT_RST_I) begin
      wr_seen_q <= 1'b0;
    end else if (RAM_WR_O.we) begin
      wr_seen_q <= 1'b1;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (RAM_WR_O.we) begin
      last_addr_q <= RAM_WR_O.addr;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_latch; $fell(RST_I) |=> BOOT_MODE_O == $past(FLASH_SUPPLY_HV_I && MODE_SEL_HV_I); endproperty
  property p_drop; BOOT_MODE_O && !MODE_SEL_HV_I |=> !BOOT_MODE_O; endproperty
  property p_wdt; BOOT_MODE_O && WDT_RST_I && MODE_SEL_HV_I |=> BOOT_MODE_O; endproperty
  property p_int_block; INT_BLOCK_O == FLASH_ERASE_O; endproperty
  property p_erase_cause; $rose(FLASH_ERASE_O) |-> !$past(FLASH_BLANK_I); endproperty
  property p_erase_end; FLASH_ERASE_O && FLASH_ERASE_DONE_I |-> ##[1:2] !FLASH_ERASE_O; endproperty
  property p_wr_range;
    RAM_WR_O.we |-> RAM_WR_O.addr <= 16'hFF6D && RAM_WR_O.addr < 16'hFBE0 + LOAD_BYTES;
  endproperty
  property p_wr_first; RAM_WR_O.we && !wr_seen_q |-> RAM_WR_O.addr == 16'hFBE0; endproperty
  property p_wr_next; RAM_WR_O.we && wr_seen_q |-> RAM_WR_O.addr == last_addr_q + 16'h0001; endproperty
  property p_res_hold; RAM_WR_O.we || FLASH_ERASE_O |-> RES_RAM_BUSY_O && BOOT_MODE_O; endproperty
  property p_branch; CPU_BRANCH_O |-> (CPU_PC_O == 16'hFBE0 && TXD_O && TXD_OE_O) [*4]; endproperty
  property p_release; CPU_BRANCH_O |=> !RES_RAM_BUSY_O; endproperty

  a_latch: assert property (p_latch)
    else $error("boot latch differs from mode pins");
  a_drop: assert property (p_drop)
    else $error("boot latch kept without mode select voltage");
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset cleared boot latch");
  a_int_block: assert property (p_int_block)
    else $error("interrupt block differs from erase");
  a_erase_cause: assert property (p_erase_cause)
    else $error("erase started on blank flash");
  a_erase_end: assert property (p_erase_end)
    else $error("erase request held after done");
  a_wr_range: assert property (p_wr_range)
    else $error("program write outside window");
  a_wr_first: assert property (p_wr_first)
    else $error("first program write not at window base");
  a_wr_next: assert property (p_wr_next)
    else $error("program writes not consecutive");
  a_res_hold: assert property (p_res_hold)
    else $error("reserved RAM released while loading");
  a_branch: assert property (p_branch)
    else $error("branch target or transmit pin wrong");
  a_release: assert property (p_release)
    else $error("reserved RAM held after branch");

  c_erase: cover property ($rose(FLASH_ERASE_O));
  c_write: cover property (RAM_WR_O.we);
  c_branch: cover property (CPU_BRANCH_O);
endmodule : sbl_boot_loader_checker

bind sbl_boot_loader sbl_boot_loader_checker #(.LOAD_BYTES(LOAD_BYTES)) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .WDT_RST_I(WDT_RST_I),
  .FLASH_SUPPLY_HV_I(FLASH_SUPPLY_HV_I), .MODE_SEL_HV_I(MODE_SEL_HV_I), .BOOT_MODE_O(BOOT_MODE_O),
  .TXD_O(TXD_O), .TXD_OE_O(TXD_OE_O), .FLASH_BLANK_I(FLASH_BLANK_I),
  .FLASH_ERASE_DONE_I(FLASH_ERASE_DONE_I), .FLASH_ERASE_O(FLASH_ERASE_O), .INT_BLOCK_O(INT_BLOCK_O),
  .RAM_WR_O(RAM_WR_O), .RES_RAM_BUSY_O(RES_RAM_BUSY_O), .CPU_BRANCH_O(CPU_BRANCH_O), .CPU_PC_O(CPU_PC_O)
);

// [tb/sbl_boot_loader_tb_top.sv]
// Self-checking bench of the serial boot loader
`timescale 1ns/1ps
`include "sbl_defines.svh"
module sbl_boot_loader_tb_top;
  import sbl_pkg::*;
  localparam int LOAD_N = 4;
  localparam int BIT_CYC = 40;
  logic clk, rst, wdt, fhv, mhv, rxd, blank, edone, re, we;
  logic boot, txd, txd_oe, erase, intb, res_busy, branch;
  logic [3:0] addr;
  logic [15:0] wdata, pc, rdata, rd;
  sbl_ram_wr_t ram_wr;
  int failures = 0;
  int total_checks = 0;
  int wr_idx = 0;
  // Pin rows: flash supply, mode select, expected boot latch
  logic [2:0] mode_rows [5] = '{3'b111, 3'b000, 3'b010, 3'b100, 3'b111};
  // Program image; a real one sets its stack first and skips FB80 to FB8F
  logic [7:0] load_data [LOAD_N] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};

  sbl_boot_loader #(.LOAD_BYTES(LOAD_N), .DIV_W(16)) dut (
    .CORE_CLK_I(clk), .RST_I(rst), .WDT_RST_I(wdt), .FLASH_SUPPLY_HV_I(fhv), .MODE_SEL_HV_I(mhv),
    .BOOT_MODE_O(boot), .RXD_I(rxd), .TXD_O(txd), .TXD_OE_O(txd_oe), .FLASH_BLANK_I(blank),
    .FLASH_ERASE_DONE_I(edone), .FLASH_ERASE_O(erase), .INT_BLOCK_O(intb), .RAM_WR_O(ram_wr),
    .RES_RAM_BUSY_O(res_busy), .CPU_BRANCH_O(branch), .CPU_PC_O(pc), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata)
  );
  sbl_host_model #(.BIT_CYC(BIT_CYC)) host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset(input logic f, input logic m);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    fhv <= f;
    mhv <= m;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // Program bytes land in order from the window base
  always @(posedge clk) begin
    if (ram_wr.we === 1'b1) begin
      check(ram_wr.addr, 16'hFBE0 + 16'(wr_idx % LOAD_N));
      check(ram_wr.data, load_data[wr_idx % LOAD_N]);
      wr_idx++;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    wdt = 1'b0;
    fhv = 1'b0;
    mhv = 1'b0;
    blank = 1'b0;
    edone = 1'b0;
    re = 1'b0;
    we = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      do_reset(mode_rows[i][2], mode_rows[i][1]);
      repeat (2) @(posedge clk);
      #1;
      check(boot, mode_rows[i][0]);
      check(txd_oe, mode_rows[i][0]);
    end
    $display("test mode table done");
    // Last row left the loader in boot mode; host starts after the ready delay
    repeat (120) @(posedge clk);
    host.send_byte(8'h00);
    for (int n = 0; n < 20 * BIT_CYC && host.rx_count == 0; n++) @(posedge clk);
    check(host.rx_byte, 16'h0000);
    reg_rd(`SBL_REG_BAUD, rd);
    check(rd >= BIT_CYC - 1 && rd <= BIT_CYC, 1'b1);
    host.send_byte(8'hAA);
    repeat (BIT_CYC) @(posedge clk);
    check(erase, 1'b0);
    host.send_byte(8'h55);
    for (int n = 0; n < 4 * BIT_CYC && erase !== 1'b1; n++) @(posedge clk);
    #1;
    check(erase, 1'b1);
    check(intb, 1'b1);
    repeat (3) @(posedge clk);
    edone <= 1'b1;
    @(posedge clk);
    edone <= 1'b0;
    repeat (3) @(posedge clk);
    check(erase, 1'b0);
    for (int i = 0; i < LOAD_N; i++) host.send_byte(load_data[i]);
    for (int n = 0; n < 4 * BIT_CYC && pc !== 16'hFBE0; n++) @(posedge clk);
    #1;
    check(pc, 16'hFBE0);
    check(txd, 1'b1);
    check(txd_oe, 1'b1);
    check(res_busy, 1'b0);
    check(wr_idx[15:0], LOAD_N);
    check(host.rx_count, 1);
    reg_rd(`SBL_REG_CTRL, rd);
    check(rd, 16'h0000);
    reg_rd(`SBL_REG_BAUD, rd);
    check(rd >= BIT_CYC - 1 && rd <= BIT_CYC, 1'b1);
    $display("test boot download done");
    reg_wr(4'h7, 16'hFFFF);
    reg_rd(4'h7, rd);
    check(rd, 16'h0000);
    reg_wr(`SBL_REG_CTRL, 16'h0003);
    reg_rd(`SBL_REG_CTRL, rd);
    check(rd, 16'h0003);
    $display("test registers done");
    @(posedge clk);
    wdt <= 1'b1;
    blank <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(boot, 1'b1);
    check(res_busy, 1'b1);
    // Restarted loader on blank flash: no erase, same download again
    repeat (120) @(posedge clk);
    host.send_byte(8'h00);
    for (int n = 0; n < 20 * BIT_CYC && host.rx_count == 1; n++) @(posedge clk);
    check(host.rx_count, 2);
    host.send_byte(8'h55);
    for (int i = 0; i < LOAD_N; i++) host.send_byte(load_data[i]);
    for (int n = 0; n < 4 * BIT_CYC && pc !== 16'hFBE0; n++) @(posedge clk);
    #1;
    check(pc, 16'hFBE0);
    check(erase, 1'b0);
    check(wr_idx[15:0], 2 * LOAD_N);
    reg_rd(`SBL_REG_STAT, rd);
    check(rd, 16'h0600);
    $display("test watchdog done");
    @(posedge clk);
    mhv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(boot, 1'b0);
    check(txd_oe, 1'b0);
    $display("test mode drop done");
    finish_test();
  end
endmodule : sbl_boot_loader_tb_top

// [tb/sbl_host_model.sv]
// Host computer model on the asynchronous serial link
`timescale 1ns/1ps
module sbl_host_model #(
  // Scaled bit period; a real host runs 2400, 4800 or 9600 bps
  parameter int BIT_CYC = 40
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] rx_byte;
  int rx_count;

  // Line idles high through reset, as the pull-up leaves it
  initial begin
    rxd_o = 1'b1;
    rx_byte = 8'hFF;
    rx_count = 0;
  end

  // ****************************************
  // Frame out: start, 8 data LSB first, stop
  // ****************************************
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask : send_byte

  // Mid-bit sampling of device frames
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_byte[i] <= txd_i;
      repeat (BIT_CYC) @(posedge clk_i);
    end
    rx_count <= rx_count + 1;
  end
endmodule : sbl_host_model
